// >>> logic/vps_video_port.sv
`default_nettype none
// Sync and direction control for the 8-bit 4:2:2 video port
module vps_video_port
  import vps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic master_mode,
  input wire logic encode_mode,
  input wire logic hblank_invert,
  input wire logic chroma_signed,
  input wire logic [VPS_MODE_W-1:0] interface_mode,
  input wire logic clock_half_rate,
  input wire logic int_vblank,
  input wire logic int_hblank,
  input wire logic int_field_one,
  input wire logic [VPS_DATA_W-1:0] out_sample,
  input wire logic out_sample_valid,
  input wire logic vblank_in,
  output logic vblank_out,
  output logic vblank_oe,
  input wire logic hblank_in,
  output logic hblank_out,
  output logic hblank_oe,
  input wire logic field_one_lines_in,
  output logic field_one_lines_out,
  output logic field_one_lines_oe,
  output logic coding_direction,
  input wire logic [VPS_DATA_W-1:0] video_bus_in,
  output logic [VPS_DATA_W-1:0] video_bus_out,
  output logic video_bus_oe,
  output logic pixel_clock_out,
  output logic sync_vblank,
  output logic sync_hblank,
  output logic sync_field_one,
  output logic [VPS_DATA_W-1:0] in_sample,
  output logic in_sample_valid,
  output logic in_sample_chroma,
  output logic sample_enable
);
  logic div_enable;
  logic vb_o_reg, vb_o_next, hb_o_reg, hb_o_next, fl_o_reg, fl_o_next;
  logic sync_oe_reg, sync_oe_next;
  logic dir_reg, dir_next, bus_oe_reg, bus_oe_next;
  logic vb_i_reg, vb_i_next, hb_i_reg, hb_i_next, fl_i_reg, fl_i_next;
  logic [VPS_DATA_W-1:0] dout_reg, dout_next, din_reg, din_next;
  logic din_v_reg, din_v_next, din_c_reg, din_c_next;
  vps_slot_t slot_reg, slot_next;

  // Flip the offset-binary midpoint for signed chroma
  function automatic logic [VPS_DATA_W-1:0] fmt_chroma(
    input logic [VPS_DATA_W-1:0] s, input logic is_c, input logic sgn);
    fmt_chroma = (is_c && sgn) ? (s ^ VPS_SIGN_FLIP) : s;
  endfunction

  // Chroma slots depend on the selected interface mode
  function automatic logic slot_is_chroma(input vps_slot_t s,
    input logic [VPS_MODE_W-1:0] m);
    case (m)
      VPS_MODE_MUX: slot_is_chroma = (s == VPS_SLOT_CB) || (s == VPS_SLOT_Y0);
      default: slot_is_chroma = (s == VPS_SLOT_CB) || (s == VPS_SLOT_CR);
    endcase
  endfunction

  vps_clk_div u_div (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .half_rate(clock_half_rate),
    .div_enable(div_enable),
    .pixel_clock_out(pixel_clock_out)
  );

  // Sample rate follows the clock output choice
  assign sample_enable = clock_half_rate ? div_enable : 1'b1;

  // Sync pins: one shared enable so all three turn together
  always_comb begin
    sync_oe_next = master_mode; // [R8] [R15]
    vb_o_next = int_vblank; // [R1]
    hb_o_next = int_hblank ^ hblank_invert; // [R3] [R5]
    fl_o_next = int_field_one; // [R6]
    vb_i_next = master_mode ? int_vblank : vblank_in; // [R2]
    hb_i_next = master_mode ? int_hblank : (hblank_in ^ hblank_invert); // [R4] [R5]
    fl_i_next = master_mode ? int_field_one : field_one_lines_in; // [R7]
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_oe_reg <= 1'b0;
      vb_o_reg <= 1'b0;
      hb_o_reg <= 1'b0;
      fl_o_reg <= 1'b0;
      vb_i_reg <= 1'b0;
      hb_i_reg <= 1'b0;
      fl_i_reg <= 1'b0;
    end else begin
      sync_oe_reg <= sync_oe_next;
      vb_o_reg <= vb_o_next;
      hb_o_reg <= hb_o_next;
      fl_o_reg <= fl_o_next;
      vb_i_reg <= vb_i_next;
      hb_i_reg <= hb_i_next;
      fl_i_reg <= fl_i_next;
    end
  end

  // Enable only while both mode and enable agree, so a mode flip
  // never leaves a driver on against an external source
  assign vblank_oe = sync_oe_reg & master_mode; // [R15]
  assign hblank_oe = sync_oe_reg & master_mode; // [R15]
  assign field_one_lines_oe = sync_oe_reg & master_mode; // [R15]
  assign vblank_out = vb_o_reg;
  assign hblank_out = hb_o_reg;
  assign field_one_lines_out = fl_o_reg;
  assign sync_vblank = vb_i_reg;
  assign sync_hblank = hb_i_reg;
  assign sync_field_one = fl_i_reg;

  // Direction and slot sequencing; slot restarts in horizontal blanking
  always_comb begin
    dir_next = encode_mode; // [R9]
    bus_oe_next = ~encode_mode; // [R10]
    slot_next = slot_reg;
    if (hb_i_reg) begin
      slot_next = VPS_SLOT_CB;
    end else if (sample_enable) begin
      case (slot_reg)
        VPS_SLOT_CB: slot_next = VPS_SLOT_Y0;
        VPS_SLOT_Y0: slot_next = VPS_SLOT_CR;
        VPS_SLOT_CR: slot_next = VPS_SLOT_Y1;
        VPS_SLOT_Y1: slot_next = VPS_SLOT_CB;
        default: slot_next = VPS_SLOT_CB;
      endcase
    end
  end

  // Data path both ways, formatted per mode and sign setting
  always_comb begin
    dout_next = dout_reg;
    din_next = din_reg;
    din_v_next = 1'b0;
    din_c_next = din_c_reg;
    if (!encode_mode && out_sample_valid && sample_enable) begin
      dout_next = fmt_chroma(out_sample, slot_is_chroma(slot_reg, interface_mode),
        chroma_signed); // [R11] [R12]
    end
    if (encode_mode && sample_enable && !hb_i_reg && !vb_i_reg) begin
      din_c_next = slot_is_chroma(slot_reg, interface_mode); // [R11]
      din_next = fmt_chroma(video_bus_in, din_c_next, chroma_signed); // [R10] [R12]
      din_v_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dir_reg <= 1'b1;
      bus_oe_reg <= 1'b0;
      slot_reg <= VPS_SLOT_CB;
      dout_reg <= VPS_DATA_RST;
      din_reg <= VPS_DATA_RST;
      din_v_reg <= 1'b0;
      din_c_reg <= 1'b0;
    end else begin
      dir_reg <= dir_next;
      bus_oe_reg <= bus_oe_next;
      slot_reg <= slot_next;
      dout_reg <= dout_next;
      din_reg <= din_next;
      din_v_reg <= din_v_next;
      din_c_reg <= din_c_next;
    end
  end

  assign coding_direction = dir_reg; // [R9] [R13]
  assign video_bus_oe = bus_oe_reg & ~encode_mode; // [R10] [R15]
  assign video_bus_out = dout_reg;
  assign in_sample = din_reg;
  assign in_sample_valid = din_v_reg;
  assign in_sample_chroma = din_c_reg;

  // Pin direction, sync values and sample format; drivers turn off in the same cycle, the rest one edge after the cause
  a_sync_master_drive: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R8]
    master_mode ##1 master_mode |-> vblank_oe && hblank_oe && field_one_lines_oe)
    else $error("sync pins not driven in master mode");
  a_sync_slave_off: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R15]
    !master_mode |-> !vblank_oe && !hblank_oe && !field_one_lines_oe)
    else $error("sync driver on in slave mode");
  a_vblank_out_val: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R1]
    master_mode |=> vblank_out == $past(int_vblank))
    else $error("vblank output mismatch");
  a_hblank_pol: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R3]
    1'b1 |=> hblank_out == ($past(int_hblank) ^ $past(hblank_invert)))
    else $error("hblank polarity wrong");
  a_slave_hblank_in: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R4]
    !master_mode |=> sync_hblank == ($past(hblank_in) ^ $past(hblank_invert)))
    else $error("hblank input misread");
  a_slave_vblank_in: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R2]
    !master_mode |=> sync_vblank == $past(vblank_in))
    else $error("vblank input misread");
  a_field_out_val: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R6]
    master_mode |=> field_one_lines_out == $past(int_field_one))
    else $error("field output mismatch");
  a_slave_field_in: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R7]
    !master_mode |=> sync_field_one == $past(field_one_lines_in))
    else $error("field input misread");
  a_dir_follows: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R9]
    $changed(encode_mode) |=> coding_direction == $past(encode_mode))
    else $error("coding direction late");
  a_bus_encode_off: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R10]
    encode_mode |-> !video_bus_oe) else $error("bus driven while encoding");
  a_bus_decode_on: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R10]
    !encode_mode ##1 !encode_mode |-> video_bus_oe)
    else $error("bus not driven while decoding");
  a_slot_restart: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R11]
    hb_i_reg |=> slot_reg == VPS_SLOT_CB)
    else $error("sample slot not restarted in blanking");
  a_in_valid_gate: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R10]
    (!encode_mode || hb_i_reg || vb_i_reg) |=> !in_sample_valid)
    else $error("input sample taken while refused");
  a_in_sign_fmt: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R12]
    in_sample_valid |-> in_sample == ($past(video_bus_in) ^
      ((in_sample_chroma && $past(chroma_signed)) ? VPS_SIGN_FLIP : VPS_DATA_RST)))
    else $error("input sample format wrong");
  a_out_plain_fmt: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R12]
    !encode_mode && out_sample_valid && sample_enable && !chroma_signed
    |=> video_bus_out == $past(out_sample))
    else $error("unsigned output sample altered");
endmodule
`default_nettype wire

// >>> logic/vps_pkg.sv
// Notes on behaviour
// R1 - Master drives vertical blank high on inactive lines
// R2 - Slave samples vertical blank, high means inactive
// R3 - Master drives horizontal blank high when inactive
// R4 - Slave samples horizontal blank, high means blanking
// R5 - Horizontal blank polarity invertible both directions
// R6 - Master drives field pin high on field one
// R7 - Slave samples field pin, high means field one
// R8 - All three sync pins switch direction together
// R9 - Coding direction low decoding, high encoding
// R10 - Video bus input encoding, driven only decoding
// R11 - Interface mode selects sample assignment and format
// R12 - Colour difference samples signed or unsigned selectable
// R13 - Others may gate their drivers with coding direction
// R14 - Clock output is input clock or half
// R15 - Input pins keep output drivers disabled
`default_nettype none
package vps_pkg;
  localparam int VPS_DATA_W = 8;
  localparam int VPS_MODE_W = 2;
  localparam logic [VPS_DATA_W-1:0] VPS_SIGN_FLIP = 8'h80;
  localparam logic [VPS_DATA_W-1:0] VPS_DATA_RST = 8'h00;
  localparam logic [VPS_MODE_W-1:0] VPS_MODE_656 = 2'h0;
  localparam logic [VPS_MODE_W-1:0] VPS_MODE_MUX = 2'h1;
  localparam logic [1:0] VPS_PHASE_LAST = 2'h3;
  localparam logic [1:0] VPS_PHASE_FIRST = 2'h0;
  // Sample slot in the 4:2:2 sequence, Gray coded
  typedef enum logic [1:0] {
    VPS_SLOT_CB = 2'h0,
    VPS_SLOT_Y0 = 2'h1,
    VPS_SLOT_CR = 2'h3,
    VPS_SLOT_Y1 = 2'h2
  } vps_slot_t;
endpackage
`default_nettype wire

// >>> logic/vps_clk_div.sv
`default_nettype none
// Half-rate enable plus registered clock output select
module vps_clk_div
  import vps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic half_rate,
  output logic div_enable,
  output logic pixel_clock_out
);
  logic tog_reg;
  logic tog_next;
  logic out_reg;
  logic out_next;

  // Toggle gives one-cycle enable every other cycle
  always_comb begin
    tog_next = ~tog_reg;
    out_next = half_rate ? tog_reg : 1'b1;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tog_reg <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      tog_reg <= tog_next;
      out_reg <= out_next;
    end
  end

  assign div_enable = tog_reg;
  // Full rate passes the input clock straight out; divided rate uses the registered toggle
  assign pixel_clock_out = half_rate ? out_reg : sys_clk; // [R14]

  a_div_alternates: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R14]
    div_enable |=> !div_enable) else $error("divider enable not alternating");
endmodule
`default_nettype wire

// >>> testbench/vps_far_end.sv
`default_nettype none
// Video source/sink on the far side of the port
module vps_far_end
  import vps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic sync_source,
  input wire logic hblank_invert,
  input wire logic coding_direction,
  input wire logic [VPS_DATA_W-1:0] seed_data,
  output logic vblank_line,
  output logic hblank_line,
  output logic field_line,
  output logic [VPS_DATA_W-1:0] bus_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] pos_reg;
  logic [VPS_DATA_W-1:0] data_reg;
  // Changes on the falling edge, well clear of the sampling edge
  always_ff @(negedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pos_reg <= 8'h00;
      data_reg <= 8'h00;
    end else begin
      pos_reg <= pos_reg + 8'h01;
      data_reg <= seed_data;
    end
  end
  // Undriven lines show an inverted, moving pattern, never a stale value
  assign vblank_line = (pos_reg[7:6] == 2'h3) ^ ~sync_source;
  assign hblank_line = (pos_reg[2:0] >= 3'h6) ^ hblank_invert ^ ~sync_source;
  assign field_line = pos_reg[7] ^ ~sync_source;
  // Bus carries the seed data while the codec accepts data, its inverse otherwise
  assign bus_line = coding_direction ? data_reg : ~data_reg;
endmodule
`default_nettype wire

// >>> testbench/video_port_sync_and_direction_bench.sv
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module video_port_sync_and_direction_bench
  import vps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, sys_rst, master_mode, encode_mode, hblank_invert, chroma_signed;
  logic clock_half_rate, int_vblank, int_hblank, int_field_one, out_sample_valid;
  logic [VPS_MODE_W-1:0] interface_mode;
  logic [VPS_DATA_W-1:0] out_sample, seed_data, bus_line, video_bus_out, in_sample;
  logic [VPS_DATA_W-1:0] m_din, m_dout;
  logic m_tog, m_en, m_hb, m_vb, m_valid, m_chr, pix_hi, pix_lo;
  logic vblank_out, vblank_oe, hblank_out, hblank_oe, field_out, field_oe, coding_direction;
  logic video_bus_oe, pixel_clock_out, sync_vblank, sync_hblank, sync_field_one;
  logic in_sample_valid, in_sample_chroma, sample_enable, vb_line, hb_line, fd_line;
  logic e_m, e_enc, e_inv, e_cs, e_iv, e_ih, e_if, e_vp, e_hp, e_fp, pix_prev;
  int err_total, total_checks, seed, i, quiet, m_slot;
  // Pin levels resolved from whoever drives them
  wire vb_pin = vblank_oe ? vblank_out : vb_line;
  wire hb_pin = hblank_oe ? hblank_out : hb_line;
  wire fd_pin = field_oe ? field_out : fd_line;
  wire [VPS_DATA_W-1:0] bus_pin = video_bus_oe ? video_bus_out : bus_line;
  vps_video_port dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .master_mode(master_mode),
    .encode_mode(encode_mode), .hblank_invert(hblank_invert), .chroma_signed(chroma_signed),
    .interface_mode(interface_mode), .clock_half_rate(clock_half_rate),
    .int_vblank(int_vblank), .int_hblank(int_hblank), .int_field_one(int_field_one),
    .out_sample(out_sample), .out_sample_valid(out_sample_valid), .vblank_in(vb_pin),
    .vblank_out(vblank_out), .vblank_oe(vblank_oe), .hblank_in(hb_pin),
    .hblank_out(hblank_out), .hblank_oe(hblank_oe), .field_one_lines_in(fd_pin),
    .field_one_lines_out(field_out), .field_one_lines_oe(field_oe),
    .coding_direction(coding_direction), .video_bus_in(bus_pin),
    .video_bus_out(video_bus_out), .video_bus_oe(video_bus_oe),
    .pixel_clock_out(pixel_clock_out), .sync_vblank(sync_vblank), .sync_hblank(sync_hblank),
    .sync_field_one(sync_field_one), .in_sample(in_sample), .in_sample_valid(in_sample_valid),
    .in_sample_chroma(in_sample_chroma), .sample_enable(sample_enable));
  vps_far_end far (.sys_clk(sys_clk), .sys_rst(sys_rst), .sync_source(~master_mode),
    .hblank_invert(hblank_invert), .coding_direction(coding_direction),
    .seed_data(seed_data), .vblank_line(vb_line), .hblank_line(hb_line),
    .field_line(fd_line), .bus_line(bus_line));
  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Chroma positions in the four-slot sequence for each interface mode
  function automatic logic exp_chroma(input int slot, input logic [VPS_MODE_W-1:0] md);
    exp_chroma = (md == VPS_MODE_MUX) ? (slot < 2) : (slot % 2 == 0);
  endfunction
  // Signed chroma is the offset-binary value with its top bit flipped
  function automatic logic [VPS_DATA_W-1:0] exp_fmt(input logic [VPS_DATA_W-1:0] s,
    input logic chroma, input logic sgn);
    exp_fmt = (chroma && sgn) ? (s ^ VPS_SIGN_FLIP) : s;
  endfunction
  // What the design saw at each sampling edge, and the sample path stepped alongside
  always @(posedge sys_clk) begin
    {e_m, e_enc, e_inv, e_cs} = {master_mode, encode_mode, hblank_invert, chroma_signed};
    {e_iv, e_ih, e_if, e_vp, e_hp, e_fp} = {int_vblank, int_hblank, int_field_one,
      vb_pin, hb_pin, fd_pin};
    if (sys_rst) begin
      m_tog = 1'b0;
      m_hb = 1'b0;
      m_vb = 1'b0;
      m_slot = 0;
      m_valid = 1'b0;
      m_chr = 1'b0;
      m_din = VPS_DATA_RST;
      m_dout = VPS_DATA_RST;
    end else begin
      m_en = clock_half_rate ? m_tog : 1'b1;
      m_valid = encode_mode && m_en && !m_hb && !m_vb;
      if (m_valid) begin
        m_chr = exp_chroma(m_slot, interface_mode);
        m_din = exp_fmt(bus_pin, m_chr, chroma_signed);
      end
      if (!encode_mode && out_sample_valid && m_en) begin
        m_dout = exp_fmt(out_sample, exp_chroma(m_slot, interface_mode), chroma_signed);
      end
      m_slot = m_hb ? 0 : (m_en ? (m_slot + 1) % 4 : m_slot);
      m_hb = master_mode ? int_hblank : (hb_pin ^ hblank_invert);
      m_vb = master_mode ? int_vblank : vb_pin;
      m_tog = ~m_tog;
    end
  end
  // Clock output read clear of the edges that move it
  always @(posedge sys_clk) #1 pix_hi = pixel_clock_out;
  always @(negedge sys_clk) #1 pix_lo = pixel_clock_out;
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check_reset();
    `CHK(coding_direction, 1'b1)
    `CHK({vblank_oe, hblank_oe, field_oe, video_bus_oe}, 4'h0)
    `CHK({in_sample_valid, video_bus_out}, 9'h000)
  endtask
  // Sync, direction and sample checks for the edge just past
  task automatic check_port();
    `CHK({vblank_oe, hblank_oe, field_oe}, {3{e_m}})
    `CHK(coding_direction, e_enc)
    `CHK(video_bus_oe, ~e_enc)
    `CHK({vblank_out, hblank_out, field_out}, {e_iv, e_ih ^ e_inv, e_if})
    if (e_m) begin
      `CHK({sync_vblank, sync_hblank, sync_field_one}, {e_iv, e_ih, e_if})
    end else begin
      `CHK(sync_vblank, e_vp)
      `CHK(sync_hblank, e_hp ^ e_inv)
      `CHK(sync_field_one, e_fp)
    end
    `CHK({in_sample_valid, in_sample_chroma}, {m_valid, m_chr})
    `CHK(in_sample, m_din)
    `CHK(video_bus_out, m_dout)
    if (clock_half_rate) begin
      `CHK(pixel_clock_out, ~pix_prev)
    end else begin
      `CHK({pix_hi, pix_lo}, 2'h2)
    end
  endtask
  // Random traffic, modes held for runs of 16 cycles, reset in mid-run
  initial begin
    seed = 32'h2973;
    {err_total, total_checks, quiet} = 0;
    {master_mode, encode_mode, hblank_invert, chroma_signed, clock_half_rate} = 5'h00;
    {int_vblank, int_hblank, int_field_one, out_sample_valid} = 4'h0;
    {interface_mode, out_sample, seed_data, pix_prev} = 0;
    sys_rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    check_reset();
    sys_rst = 1'b0;
    for (i = 0; i < 4000; i++) begin
      @(negedge sys_clk);
      if (sys_rst) check_reset();
      else if (quiet == 0 && i > 0) check_port();
      pix_prev = pixel_clock_out;
      quiet = (quiet > 0) ? quiet - 1 : 0;
      if (i % 16 == 0) begin
        {master_mode, encode_mode, hblank_invert, chroma_signed, clock_half_rate} =
          5'($random(seed));
        interface_mode = (i % 32 == 0) ? VPS_MODE_656 : VPS_MODE_MUX;
        quiet = 2;
      end
      {int_vblank, int_hblank, int_field_one, out_sample_valid} = 4'($random(seed));
      out_sample = 8'($random(seed));
      seed_data = 8'($random(seed));
      if (i == 2000) sys_rst = 1'b1;
      if (i == 2002) sys_rst = 1'b0;
      if (i == 2002) quiet = 3;
    end
    wrap_up();
  end
endmodule
`default_nettype wire
